// [rtl/sensor_range_power_ctrl.sv]
// Purpose: apb register bank for range, power, wake-up and conversion pacing
// Assumes: apb slave, zero wait states, 32-bit data
// Notes: two channel sequencers are instantiated below
// How it works
// R1 - the channel 2 range code picks 5, 10 or 20 pF full scale, codes 10 and 11 both 20 pF.
// R2 - reserved bits 7:6 of the range register and 7:3 of the power register read zero.
// R3 - every reset clears the power register, standby off and both channels up.
// R4 - power bit 0 set to 1 puts both channels in standby, set to 0 leaves it.
// R5 - in standby, conversions run at the normal interval times the standby divider plus one.
// R6 - a wake-up event clears the standby bit in hardware, software may clear it too.
// R7 - power bit 1 powers channel 1 down when 1 and up when 0.
// R8 - power bit 2 powers channel 2 down when 1 and up when 0.
// R9 - wake register bit 0 enables channel 1 absolute-threshold wake-up.
// R10 - the power register is always readable and writable except per-bit limits.
// R11 - a single-conversion trigger runs only powered channels and clears itself at the end.
// R12 - with and/or select 1 both thresholds must hit, with 0 either one suffices.
// R13 - a powered-down channel converts nothing and raises no wake-up.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
module sensor_range_power_ctrl
    import sense_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ch1_abs_hit,
    input wire logic ch1_roc_hit,
    output logic [4:0] ch2_full_scale_pf,
    output logic standby_active,
    output logic irq
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] power_ctrl_q, power_ctrl_d;
    logic [7:0] range_q, range_d;
    logic [7:0] wake1_q, wake1_d;
    logic [7:0] single_q, single_d;
    logic [7:0] sdiv_q, sdiv_d;
    logic [15:0] interval_q, interval_d;
    logic [NUM_EV-1:0] status_q, status_d;
    logic [NUM_EV-1:0] irq_en_q, irq_en_d;
    logic [31:0] rdata_q, rdata_d;
    logic [4:0] fs_q, fs_d;
    logic [15:0] tick_q, tick_d;
    logic [7:0] sbcnt_q, sbcnt_d;
    logic pend1_q, pend1_d;
    logic pend2_q, pend2_d;
    logic wr, rd, mapped;
    logic [7:0] idx;
    logic pace_start, any_wake, any_done, sb_exit;
    logic shot_q, trig_fire;

    sense_conv_if c1 ();
    sense_conv_if c2 ();

    // range code to full scale
    function automatic logic [4:0] range_pf(input logic [1:0] code);
        case (code)
            2'b00: range_pf = RANGE_5PF; // R1
            2'b01: range_pf = RANGE_10PF; // R1
            default: range_pf = RANGE_20PF; // R1
        endcase
    endfunction : range_pf

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign idx = paddr[9:2];
    // unmapped or unaligned accesses change nothing and read zero
    assign wr = psel && penable && pwrite && mapped;
    // reads are decoded in the setup phase so that prdata comes from a flop
    assign rd = psel && !penable && !pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        if (idx == IDX_SINGLE_CONV || idx == IDX_RANGE || idx == IDX_POWER
            || idx == IDX_WAKE1 || idx == IDX_STANDBY_DIV || idx == IDX_STATUS
            || idx == IDX_IRQ_CLEAR || idx == IDX_IRQ_ENABLE
            || idx == IDX_CONV_INTERVAL || idx == IDX_RANGE_PF) begin
            mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
        end else begin
            mapped = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // conversion pacing: normal interval, stretched in standby
    // ----------------------------------------------------------------
    always_comb begin
        tick_d = tick_q;
        sbcnt_d = sbcnt_q;
        pace_start = 1'b0;
        if (tick_q == 16'h0000) begin
            tick_d = interval_q;
            if (!power_ctrl_q[POS_STANDBY] || sbcnt_q == 8'h00) begin
                pace_start = !single_q[POS_SC_EN];
                sbcnt_d = sdiv_q; // R5
            end else begin
                sbcnt_d = sbcnt_q - 8'h01; // R5
            end
        end else begin
            tick_d = tick_q - 16'h0001;
        end
    end

    // a pending flag also drops on power-down, else a dropped conversion would hang the trigger
    assign pend1_d = trig_fire ? !c1.powered_down
                   : (single_q[POS_TRIG] && pend1_q && !c1.done && !c1.powered_down); // R11
    assign pend2_d = trig_fire ? !c2.powered_down
                   : (single_q[POS_TRIG] && pend2_q && !c2.done && !c2.powered_down); // R11
    // the trigger adds one start pulse; each sequencer ignores it while powered down
    assign c1.start = pace_start || shot_q; // R11
    assign c2.start = c1.start;
    assign c1.powered_down = power_ctrl_q[POS_CH1_PD]; // R7
    assign c2.powered_down = power_ctrl_q[POS_CH2_PD]; // R8
    assign c1.abs_en = wake1_q[POS_ABS_EN]; // R9
    assign c1.roc_en = wake1_q[POS_ROC_EN];
    assign c1.and_or = wake1_q[POS_AND_OR]; // R12
    assign c1.abs_hit = ch1_abs_hit;
    assign c1.roc_hit = ch1_roc_hit;
    assign c2.abs_en = 1'b0;
    assign c2.roc_en = 1'b0;
    assign c2.and_or = 1'b0;
    assign c2.abs_hit = 1'b0;
    assign c2.roc_hit = 1'b0;

    assign any_wake = c1.wake || c2.wake;
    assign any_done = c1.done || c2.done;
    assign sb_exit = any_wake && power_ctrl_q[POS_STANDBY];

    // ----------------------------------------------------------------
    // register next state
    // ----------------------------------------------------------------
    always_comb begin
        power_ctrl_d = power_ctrl_q;
        range_d = range_q;
        wake1_d = wake1_q;
        single_d = single_q;
        sdiv_d = sdiv_q;
        interval_d = interval_q;
        irq_en_d = irq_en_q;
        status_d = status_q;
        trig_fire = 1'b0;
        if (wr && idx == IDX_POWER) begin
            power_ctrl_d = pwdata[7:0] & MASK_POWER; // R4 R10
        end else if (wr && idx == IDX_RANGE) begin
            range_d = pwdata[7:0] & MASK_RANGE; // R2
        end else if (wr && idx == IDX_WAKE1) begin
            wake1_d = pwdata[7:0] & MASK_WAKE;
        end else if (wr && idx == IDX_SINGLE_CONV) begin
            single_d[POS_SC_EN] = pwdata[POS_SC_EN];
            if (!single_q[POS_TRIG] && pwdata[POS_TRIG] && pwdata[POS_SC_EN]) begin
                single_d[POS_TRIG] = 1'b1;
                trig_fire = 1'b1;
            end
        end else if (wr && idx == IDX_STANDBY_DIV) begin
            sdiv_d = pwdata[7:0];
        end else if (wr && idx == IDX_IRQ_ENABLE) begin
            irq_en_d = pwdata[NUM_EV-1:0];
        end else if (wr && idx == IDX_CONV_INTERVAL) begin
            interval_d = pwdata[15:0];
        end
        if (wr && idx == IDX_IRQ_CLEAR) begin
            status_d = status_q & ~pwdata[NUM_EV-1:0];
        end
        // hardware clear wins over a software write of the same cycle
        if (any_wake) begin
            power_ctrl_d[POS_STANDBY] = 1'b0; // R6
        end
        // trigger ends when every running channel has finished
        if (single_q[POS_TRIG] && !pend1_q && !pend2_q && !trig_fire) begin
            single_d[POS_TRIG] = 1'b0; // R11
        end
        // set wins over clear
        if (any_wake) begin
            status_d[EV_WAKE] = 1'b1;
        end
        if (any_done) begin
            status_d[EV_CONV_DONE] = 1'b1;
        end
        if (sb_exit) begin
            status_d[EV_STANDBY_EXIT] = 1'b1;
        end
        single_d = single_d & MASK_SINGLE;
    end

    assign fs_d = range_pf(range_q[POS_CH2_RANGE +: 2]); // R1

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd && idx == IDX_POWER) begin
            rdata_d = {24'h00_0000, power_ctrl_q & MASK_POWER}; // R2 R10
        end else if (rd && idx == IDX_RANGE) begin
            rdata_d = {24'h00_0000, range_q & MASK_RANGE}; // R2
        end else if (rd && idx == IDX_WAKE1) begin
            rdata_d = {24'h00_0000, wake1_q};
        end else if (rd && idx == IDX_SINGLE_CONV) begin
            rdata_d = {24'h00_0000, single_q};
        end else if (rd && idx == IDX_STANDBY_DIV) begin
            rdata_d = {24'h00_0000, sdiv_q};
        end else if (rd && idx == IDX_STATUS) begin
            rdata_d = {29'h0000_0000, status_q};
        end else if (rd && idx == IDX_IRQ_ENABLE) begin
            rdata_d = {29'h0000_0000, irq_en_q};
        end else if (rd && idx == IDX_CONV_INTERVAL) begin
            rdata_d = {16'h0000, interval_q};
        end else if (rd && idx == IDX_RANGE_PF) begin
            rdata_d = {27'h000_0000, fs_q};
        end
    end
    // still zero wait: data captured at the setup edge stands through the access phase,
    // so a status bit set during the access cycle shows on the next read
    assign prdata = rdata_q;

    // ----------------------------------------------------------------
    // flip-flops
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_ctrl_q <= RST_POWER; // R3
            range_q <= RST_RANGE;
            wake1_q <= RST_WAKE1;
            single_q <= RST_SINGLE;
            sdiv_q <= RST_STANDBY_DIV;
            interval_q <= RST_CONV_INTERVAL;
            status_q <= '0;
            irq_en_q <= '0;
            rdata_q <= 32'h0000_0000;
            fs_q <= RANGE_20PF;
            tick_q <= 16'h0000;
            sbcnt_q <= 8'h00;
            pend1_q <= 1'b0;
            pend2_q <= 1'b0;
        end else begin
            power_ctrl_q <= power_ctrl_d;
            range_q <= range_d;
            wake1_q <= wake1_d;
            single_q <= single_d;
            sdiv_q <= sdiv_d;
            interval_q <= interval_d;
            status_q <= status_d;
            irq_en_q <= irq_en_d;
            rdata_q <= rdata_d;
            fs_q <= fs_d;
            tick_q <= tick_d;
            sbcnt_q <= sbcnt_d;
            pend1_q <= pend1_d;
            pend2_q <= pend2_d;
        end
    end

    // single-shot start pulse, one cycle after the trigger is taken
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shot_q <= 1'b0;
        end else begin
            shot_q <= trig_fire;
        end
    end

    sense_channel u_ch1 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .cif(c1)
    );
    sense_channel u_ch2 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .cif(c2)
    );

    assign ch2_full_scale_pf = fs_q;
    assign standby_active = power_ctrl_q[POS_STANDBY];
    assign irq = |(status_q & irq_en_q);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_wake_clears_sb: assert property (@(posedge sys_clk) disable iff (sys_rst)
        any_wake |=> !power_ctrl_q[POS_STANDBY]) else $error("standby kept after wake"); // R6
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (power_ctrl_q[7:3] == 5'h00) && (range_q[7:6] == 2'b00))
        else $error("reserved bits set"); // R2
    a_range_map: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
        1'b1 |=> fs_q == ($past(range_q[POS_CH2_RANGE + 1]) ? RANGE_20PF
                          : $past(range_q[POS_CH2_RANGE]) ? RANGE_10PF : RANGE_5PF))
        else $error("full scale wrong");
    a_power_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr && idx == IDX_POWER && !any_wake) |=>
        power_ctrl_q == ($past(pwdata[7:0]) & MASK_POWER)) else $error("power write lost"); // R4
    a_ch1_pd_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
        power_ctrl_q[POS_CH1_PD] [*2] |-> !c1.done) else $error("ch1 converts while down"); // R7
    a_ch2_pd_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
        power_ctrl_q[POS_CH2_PD] [*2] |-> !c2.done) else $error("ch2 converts while down"); // R8
    a_trig_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
        trig_fire |-> ##[1:120] !single_q[POS_TRIG]) else $error("trigger stuck"); // R11
    a_abs_disabled: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wake1_q[2:0] == 3'b000) [*2] |-> !c1.wake) else $error("wake while disabled"); // R9
endmodule : sensor_range_power_ctrl

// [rtl/sense_ctrl_pkg.sv]
// Purpose: shared constants for the sensing front-end control registers
// Assumes: apb, 32-bit data, one word per register
// Notes: offsets 0x01..0x04 and 0x10..0x15 are indices; byte address is four times the index
package sense_ctrl_pkg;
    localparam logic [7:0] IDX_SINGLE_CONV = 8'h01;
    localparam logic [7:0] IDX_RANGE = 8'h02;
    localparam logic [7:0] IDX_POWER = 8'h03;
    localparam logic [7:0] IDX_WAKE1 = 8'h04;
    localparam logic [7:0] IDX_STANDBY_DIV = 8'h10;
    localparam logic [7:0] IDX_STATUS = 8'h11;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h12;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h13;
    localparam logic [7:0] IDX_CONV_INTERVAL = 8'h14;
    localparam logic [7:0] IDX_RANGE_PF = 8'h15;
    // field positions
    localparam int POS_STANDBY = 0;
    localparam int POS_CH1_PD = 1;
    localparam int POS_CH2_PD = 2;
    localparam int POS_ABS_EN = 0;
    localparam int POS_ROC_EN = 1;
    localparam int POS_AND_OR = 2;
    localparam int POS_TRIG = 0;
    localparam int POS_SC_EN = 1;
    localparam int POS_CH2_RANGE = 4;
    // writable masks: reserved bits read as zero
    localparam logic [7:0] MASK_RANGE = 8'h33;
    localparam logic [7:0] MASK_POWER = 8'h07;
    localparam logic [7:0] MASK_WAKE = 8'h07;
    localparam logic [7:0] MASK_SINGLE = 8'h03;
    // reset values
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_RANGE = 8'h22;
    localparam logic [7:0] RST_WAKE1 = 8'h00;
    localparam logic [7:0] RST_SINGLE = 8'h00;
    localparam logic [7:0] RST_STANDBY_DIV = 8'h03;
    localparam logic [15:0] RST_CONV_INTERVAL = 16'h0010;
    // full-scale values in pF
    localparam logic [4:0] RANGE_5PF = 5'h05;
    localparam logic [4:0] RANGE_10PF = 5'h0a;
    localparam logic [4:0] RANGE_20PF = 5'h14;
    // conversion length
    localparam int CONV_TIME_NS = 400;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // status bits
    localparam int EV_WAKE = 0;
    localparam int EV_CONV_DONE = 1;
    localparam int EV_STANDBY_EXIT = 2;
    localparam int NUM_EV = 3;
    typedef enum logic [1:0] {CH_IDLE, CH_CONV} conv_state_t;
endpackage : sense_ctrl_pkg

// [rtl/sense_conv_if.sv]
// Purpose: ties the register bank to a channel converter
// Assumes: single clock
// Notes: start is a one-cycle pulse
`timescale 1ns/1ns
interface sense_conv_if;
    logic start;
    logic powered_down;
    logic abs_en;
    logic roc_en;
    logic and_or;
    logic abs_hit;
    logic roc_hit;
    logic done;
    logic wake;
    modport ctrl (output start, output powered_down, output abs_en, output roc_en,
        output and_or, output abs_hit, output roc_hit, input done, input wake);
    modport conv (input start, input powered_down, input abs_en, input roc_en,
        input and_or, input abs_hit, input roc_hit, output done, output wake);
endinterface : sense_conv_if

// [rtl/sense_channel.sv]
// Purpose: one channel conversion sequencer with wake-up qualification
// Assumes: threshold hits are valid in the last conversion cycle
// Notes: a powered-down channel drops any conversion in flight
`timescale 1ns/1ns
module sense_channel
    import sense_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    sense_conv_if.conv cif
);
    conv_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic wake_q, wake_d;
    logic qual;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        wake_d = 1'b0;
        qual = cif.and_or ? (cif.abs_en && cif.roc_en && cif.abs_hit && cif.roc_hit)
                          : ((cif.abs_en && cif.abs_hit) || (cif.roc_en && cif.roc_hit));
        case (state_q)
            CH_IDLE: begin
                if (cif.start && !cif.powered_down) begin // R13
                    state_d = CH_CONV;
                    cnt_d = 8'(CONV_CYCLES - 1);
                end
            end
            CH_CONV: begin
                if (cif.powered_down) begin // R13
                    state_d = CH_IDLE;
                end else if (cnt_q == 8'h00) begin
                    state_d = CH_IDLE;
                    done_d = 1'b1;
                    wake_d = qual;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: state_d = CH_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= CH_IDLE;
            cnt_q <= 8'h00;
            done_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            wake_q <= wake_d;
        end
    end

    assign cif.done = done_q;
    assign cif.wake = wake_q;

    a_pd_no_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cif.powered_down |=> !wake_q) else $error("wake from powered-down channel"); // R13
    a_and_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == CH_CONV && cnt_q == 8'h00 && !cif.powered_down && cif.and_or
         && !cif.roc_hit) |=> !wake_q) else $error("and mode woke on one hit"); // R12
endmodule : sense_channel

// [bench/tb.sv]
// Purpose: self-checking bench for the range, power and wake register bank
// Assumes: apb slave; pready is sampled on every access cycle, no latency assumed
// Notes: only channel 1 can raise wake-up; standby conversion rate is not measured
`timescale 1ns/1ns
module tb
    import sense_ctrl_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic sys_clk;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ch1_abs_hit;
    logic ch1_roc_hit;
    logic [4:0] ch2_full_scale_pf;
    logic standby_active;
    logic irq;
    int errors;
    int compares;
    logic [32:0] exp_q[$];
    logic [31:0] rng = 32'haad3;

    sensor_range_power_ctrl DUT (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ch1_abs_hit(ch1_abs_hit),
        .ch1_roc_hit(ch1_roc_hit),
        .ch2_full_scale_pf(ch2_full_scale_pf),
        .standby_active(standby_active),
        .irq(irq)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    task chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task finish_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // one apb transfer; an idle edge follows so psel is never assigned twice at one edge
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task rd(input logic [7:0] idx, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, idx, 32'h0);
    endtask : rd

    // bounded wait for hardware to drop standby
    task wait_low();
        int n;
        n = 0;
        while (standby_active !== 1'b0 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_low

    // ----------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // read data is taken at the edge where pready is seen high
    always @(posedge sys_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() > 0) begin
                chk({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        finish_test();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic [1:0] cc;
        logic [4:0] fs;
        static logic [7:0] pw[3] = '{8'h03, 8'h01, 8'h01};
        static logic [7:0] wk[3] = '{8'h01, 8'h00, 8'h07};
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ch1_abs_hit = 1'b0;
        ch1_roc_hit = 1'b0;
        errors = 0;
        compares = 0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(IDX_POWER, 33'h0);
        rd(IDX_RANGE, 33'h22);
        rd(IDX_WAKE1, 33'h0);
        rd(8'h3f, {1'b1, 32'h0});
        apb(1'b1, IDX_IRQ_ENABLE, 32'h0);
        // every range code, reserved bits set on purpose
        for (int c = 0; c < 4; c++) begin
            r = xs();
            cc = c[1:0];
            fs = (cc == 2'd0) ? RANGE_5PF : (cc == 2'd1) ? RANGE_10PF : RANGE_20PF;
            apb(1'b1, IDX_RANGE, {r[31:8], 2'b11, cc, r[3:0]});
            rd(IDX_RANGE, {25'h0, 2'b00, cc, 2'b00, r[1:0]});
            chk({28'h0, ch2_full_scale_pf}, {28'h0, fs});
        end
        // random power writes; no wake source active yet
        for (int k = 0; k < 8; k++) begin
            r = xs();
            apb(1'b1, IDX_POWER, r);
            rd(IDX_POWER, {25'h0, r[7:0] & MASK_POWER});
            chk({32'h0, standby_active}, {32'h0, r[0]});
        end
        // wake must not fire: channel down, detection off, and-mode missing one hit
        // ch1 goes down first so no conversion can wake between the two writes below
        apb(1'b1, IDX_POWER, 32'h2);
        ch1_abs_hit <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, IDX_WAKE1, {24'h0, wk[i]});
            apb(1'b1, IDX_POWER, {24'h0, pw[i]});
            repeat (400) @(posedge sys_clk);
            chk({32'h0, standby_active}, 33'h1);
        end
        ch1_roc_hit <= 1'b1;
        wait_low();
        chk({32'h0, standby_active}, 33'h0);
        ch1_roc_hit <= 1'b0;
        apb(1'b1, IDX_WAKE1, 32'h1);
        apb(1'b1, IDX_POWER, 32'h1);
        wait_low();
        chk({32'h0, standby_active}, 33'h0);
        // let conversions in flight finish before touching status
        ch1_abs_hit <= 1'b0;
        repeat (300) @(posedge sys_clk);
        chk({32'h0, irq}, 33'h0);
        apb(1'b1, IDX_IRQ_ENABLE, 32'h1);
        chk({32'h0, irq}, 33'h1);
        apb(1'b1, IDX_IRQ_CLEAR, 32'h1);
        chk({32'h0, irq}, 33'h0);
        rd(IDX_STATUS, 33'h6);
        // trigger with both channels down clears at once
        apb(1'b1, IDX_POWER, 32'h6);
        apb(1'b1, IDX_SINGLE_CONV, 32'h3);
        rd(IDX_SINGLE_CONV, 33'h2);
        // trigger with ch1 powered holds until its conversion ends
        apb(1'b1, IDX_POWER, 32'h4);
        apb(1'b1, IDX_SINGLE_CONV, 32'h3);
        rd(IDX_SINGLE_CONV, 33'h3);
        repeat (120) @(posedge sys_clk);
        rd(IDX_SINGLE_CONV, 33'h2);
        // reset in mid-run
        apb(1'b1, IDX_POWER, 32'h7);
        sys_rst <= 1'b1;
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(IDX_POWER, 33'h0);
        chk({32'h0, standby_active}, 33'h0);
        rd(IDX_RANGE, 33'h22);
        chk({28'h0, ch2_full_scale_pf}, {28'h0, RANGE_20PF});
        finish_test();
    end
endmodule : tb
